/* rtl/swr_pkg.sv */
// Shared constants for the single-wire ROM command layer.
// Assumes a 125 MHz system clock and a bit-slot layer on the same clock.
package swr_pkg;

	localparam int CLK_MHZ      = 125;
	localparam int RST_LONG_US  = 690;
	localparam int RST_SHORT_US = 80;
	// Long is a least time, short a greatest, whole microseconds, so the products are exact.
	localparam int RST_LONG_CYC  = RST_LONG_US * CLK_MHZ;
	localparam int RST_SHORT_CYC = RST_SHORT_US * CLK_MHZ;

	localparam int CMD_BITS = 8;
	localparam int ID_BITS  = 64;
	localparam int IDX_W    = 6;

	localparam logic [7:0] CMD_READ_ID  = 8'h33;
	localparam logic [7:0] CMD_MATCH    = 8'h55;
	localparam logic [7:0] CMD_SEARCH   = 8'hF0;
	localparam logic [7:0] CMD_ALM_SRCH = 8'hEC;
	localparam logic [7:0] CMD_SKIP     = 8'hCC;
	localparam logic [7:0] CMD_RESUME   = 8'hA5;
	localparam logic [7:0] CMD_OD_SKIP  = 8'h3C;
	localparam logic [7:0] CMD_OD_MATCH = 8'h69;

	localparam logic [11:0] ALARM_FLAGS_OFFSET = 12'h214;
	localparam int ALM_TEMP_LO = 0;
	localparam int ALM_TEMP_HI = 1;
	localparam int ALM_HUM_LO  = 2;
	localparam int ALM_HUM_HI  = 3;
	localparam int ALM_BOR     = 4;

	localparam logic [7:0] CRC8_POLY_REV = 8'h8C;
	localparam logic [5:0] IDX_LAST      = 6'h3F;

	typedef enum logic [2:0] {
		SWR_WAIT_RST = 3'b000,
		SWR_CMD      = 3'b001,
		SWR_READ_ID  = 3'b010,
		SWR_MATCH    = 3'b011,
		SWR_SRCH_TRU = 3'b100,
		SWR_SRCH_CMP = 3'b101,
		SWR_SRCH_DIR = 3'b110,
		SWR_FUNC     = 3'b111
	} swr_state_e;

	// Reflected CRC-8 over family code and serial number, LSB first.
	function automatic logic [7:0] swr_crc8(input logic [55:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			fb = c[0] ^ d[i];
			c = c >> 1;
			if (fb) begin
				c = c ^ CRC8_POLY_REV;
			end
		end
		return c;
	endfunction

endpackage

/* rtl/swr_id_rom.sv */
// Identity store: family code, serial number and CRC, one bit per read.
// Assumes the index is held steady for a cycle before the bit is used.
`timescale 1ns/10ps
`default_nettype none
module swr_id_rom #(
	// Arbitrary neutral identity values.
	parameter logic [7:0]  FAMILY = 8'h5A,
	parameter logic [47:0] SERIAL = 48'h000000000001
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [5:0] idx,
	output logic            bit_q
);

	localparam logic [63:0] ID =
		{swr_pkg::swr_crc8({SERIAL, FAMILY}), SERIAL, FAMILY};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_q <= 1'b0;
		end else begin
			bit_q <= ID[idx];
		end
	end

endmodule // swr_id_rom
`default_nettype wire

/* rtl/swr_cmd_rx.sv */
// Command byte receiver, least significant bit first.
// Assumes bit strobes come from same-clock slot logic.
`timescale 1ns/10ps
`default_nettype none
module swr_cmd_rx (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic       bit_stb,
	input  wire logic       bit_val,
	output logic [7:0]      byte_q,
	output logic            done_q
);

	logic [2:0] cnt_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_q <= 8'h00;
			cnt_q  <= 3'h0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (clear) begin
				cnt_q <= 3'h0;
			end else if (bit_stb) begin
				byte_q <= {bit_val, byte_q[7:1]};
				cnt_q  <= cnt_q + 3'h1;
				done_q <= (cnt_q == 3'h7);
			end
		end
	end

endmodule // swr_cmd_rx
`default_nettype wire

/* rtl/swr_rom_layer.sv */
// ROM command layer of a single-wire bus slave.
// Assumes a same-clock slot layer that times reset, presence and bit slots,
// and gates the pull-down request into the actual read slot window.
`timescale 1ns/10ps
`default_nettype none
module swr_rom_layer #(
	parameter logic [7:0]  FAMILY        = 8'h5A,
	parameter logic [47:0] SERIAL        = 48'h000000000001,
	parameter int          RST_CNT_W     = 17,
	parameter int          RST_LONG_CYC  = swr_pkg::RST_LONG_CYC,
	parameter int          RST_SHORT_CYC = swr_pkg::RST_SHORT_CYC
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 rst_det,
	input  wire logic [RST_CNT_W-1:0] rst_low_cyc,
	input  wire logic                 wr_bit_stb,
	input  wire logic                 wr_bit_val,
	input  wire logic                 rd_slot_stb,
	input  wire logic [7:0]           alarm_flags,
	input  wire logic                 temp_alarm_en,
	input  wire logic                 hum_alarm_en,
	output logic                      od_line_o_q,
	output logic                      od_line_oe_q,
	output logic                      overdrive_flag_q,
	output logic                      resume_flag_q,
	output logic                      func_go_q,
	output logic                      func_active_q,
	output logic [7:0]                rom_cmd_q
);

	// The reset length counter must reach the long threshold, and a short
	// reset must be strictly shorter than a long one.
	if (RST_LONG_CYC >= (1 << RST_CNT_W) || RST_LONG_CYC < 1) begin : g_chk_l
		$error("reset length counter too narrow for long reset");
	end
	if (RST_SHORT_CYC >= RST_LONG_CYC || RST_SHORT_CYC < 1) begin : g_chk_s
		$error("short reset must be shorter than long reset");
	end
	if (RST_CNT_W < 2 || RST_CNT_W > 30) begin : g_chk_w
		$error("reset length counter width out of range");
	end
	if (swr_pkg::ID_BITS != (1 << swr_pkg::IDX_W)) begin : g_chk_i
		$error("identity index does not span the identity code");
	end
	if (swr_pkg::CMD_BITS != 8) begin : g_chk_c
		$error("command receiver is built for eight-bit commands");
	end

	localparam logic [RST_CNT_W-1:0] LONG_CNT =
		RST_CNT_W'(RST_LONG_CYC);
	localparam logic [RST_CNT_W-1:0] SHORT_CNT =
		RST_CNT_W'(RST_SHORT_CYC);

	swr_pkg::swr_state_e st_q;
	swr_pkg::swr_state_e st_d;

	logic [5:0] idx_q;
	logic       id_bit;
	logic [7:0] cmd_byte;
	logic       cmd_done;
	logic       od_match_q;
	logic       last_bit;
	logic       bit_eq;
	logic       sel_ok;
	logic       addr_cmd;
	logic       alarm_qual;
	logic       long_rst;
	logic       short_rst;
	logic       cmd_take;
	logic       id_step;

	// Alarm flags are qualified by their enables; brownout is never masked.
	function automatic logic alarm_any(input logic [7:0] f,
					   input logic t_en,
					   input logic h_en);
		logic q;
		q = f[swr_pkg::ALM_BOR];
		q = q | (t_en & (f[swr_pkg::ALM_TEMP_LO] | f[swr_pkg::ALM_TEMP_HI]));
		q = q | (h_en & (f[swr_pkg::ALM_HUM_LO] | f[swr_pkg::ALM_HUM_HI]));
		return q;
	endfunction

	swr_cmd_rx u_cmd_rx (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clear   (rst_det),
		.bit_stb (wr_bit_stb && st_q == swr_pkg::SWR_CMD),
		.bit_val (wr_bit_val),
		.byte_q  (cmd_byte),
		.done_q  (cmd_done)
	);

	swr_id_rom #(
		.FAMILY (FAMILY),
		.SERIAL (SERIAL)
	) u_id_rom (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.idx     (idx_q),
		.bit_q   (id_bit)
	);

	assign last_bit   = (idx_q == swr_pkg::IDX_LAST);
	assign bit_eq     = (wr_bit_val == id_bit);
	assign alarm_qual = alarm_any(alarm_flags, temp_alarm_en,
				      hum_alarm_en);
	assign long_rst   = (rst_low_cyc >= LONG_CNT);
	assign short_rst  = (rst_low_cyc <= SHORT_CNT);
	assign id_step    = (st_q == swr_pkg::SWR_READ_ID && rd_slot_stb) ||
			    (st_q == swr_pkg::SWR_MATCH && wr_bit_stb) ||
			    (st_q == swr_pkg::SWR_SRCH_DIR && wr_bit_stb);

	// A command that completes together with a bus reset is dropped, so a
	// long reset can never lose to an overdrive skip decoded in its cycle.
	assign cmd_take   = cmd_done && !rst_det;

	// Commands that address a device by its code.
	assign addr_cmd = cmd_take &&
			  (cmd_byte == swr_pkg::CMD_MATCH    ||
			   cmd_byte == swr_pkg::CMD_OD_MATCH ||
			   cmd_byte == swr_pkg::CMD_SEARCH   ||
			   cmd_byte == swr_pkg::CMD_ALM_SRCH);

	// A full 64-bit selection by match or search completed.
	assign sel_ok = wr_bit_stb && bit_eq && last_bit &&
			(st_q == swr_pkg::SWR_MATCH ||
			 st_q == swr_pkg::SWR_SRCH_DIR);

	always_comb begin
		st_d = st_q;
		if (rst_det) begin
			st_d = swr_pkg::SWR_CMD;
		end else begin
			unique case (st_q)
			swr_pkg::SWR_WAIT_RST: begin
				st_d = swr_pkg::SWR_WAIT_RST;
			end
			swr_pkg::SWR_CMD: begin
				if (cmd_done) begin
					unique case (cmd_byte)
					swr_pkg::CMD_READ_ID: begin
						st_d = swr_pkg::SWR_READ_ID;
					end
					swr_pkg::CMD_MATCH,
					swr_pkg::CMD_OD_MATCH: begin
						st_d = swr_pkg::SWR_MATCH;
					end
					swr_pkg::CMD_SEARCH: begin
						st_d = swr_pkg::SWR_SRCH_TRU;
					end
					swr_pkg::CMD_ALM_SRCH: begin
						st_d = alarm_qual ? swr_pkg::SWR_SRCH_TRU
								  : swr_pkg::SWR_WAIT_RST;
					end
					swr_pkg::CMD_SKIP,
					swr_pkg::CMD_OD_SKIP: begin
						st_d = swr_pkg::SWR_FUNC;
					end
					swr_pkg::CMD_RESUME: begin
						st_d = resume_flag_q ? swr_pkg::SWR_FUNC
								     : swr_pkg::SWR_WAIT_RST;
					end
					default: begin
						st_d = swr_pkg::SWR_WAIT_RST;
					end
					endcase
				end
			end
			swr_pkg::SWR_READ_ID: begin
				if (rd_slot_stb && last_bit) begin
					st_d = swr_pkg::SWR_FUNC;
				end
			end
			swr_pkg::SWR_MATCH: begin
				if (wr_bit_stb) begin
					if (!bit_eq) begin
						st_d = swr_pkg::SWR_WAIT_RST;
					end else if (last_bit) begin
						st_d = swr_pkg::SWR_FUNC;
					end
				end
			end
			swr_pkg::SWR_SRCH_TRU: begin
				if (rd_slot_stb) begin
					st_d = swr_pkg::SWR_SRCH_CMP;
				end
			end
			swr_pkg::SWR_SRCH_CMP: begin
				if (rd_slot_stb) begin
					st_d = swr_pkg::SWR_SRCH_DIR;
				end
			end
			swr_pkg::SWR_SRCH_DIR: begin
				if (wr_bit_stb) begin
					if (!bit_eq) begin
						st_d = swr_pkg::SWR_WAIT_RST;
					end else if (last_bit) begin
						st_d = swr_pkg::SWR_FUNC;
					end else begin
						st_d = swr_pkg::SWR_SRCH_TRU;
					end
				end
			end
			swr_pkg::SWR_FUNC: begin
				st_d = swr_pkg::SWR_FUNC;
			end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= swr_pkg::SWR_WAIT_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Identity bit index, walking upward from the least significant bit.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q <= 6'h00;
		end else if (rst_det || cmd_done) begin
			idx_q <= 6'h00;
		end else if (id_step) begin
			idx_q <= idx_q + 6'h01;
		end
	end

	// Remember the last command, and whether it was an overdrive match.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rom_cmd_q  <= 8'h00;
			od_match_q <= 1'b0;
		end else if (cmd_take) begin
			rom_cmd_q  <= cmd_byte;
			od_match_q <= (cmd_byte == swr_pkg::CMD_OD_MATCH);
		end
	end

	// A new selection clears the flag first; success sets it again, and the
	// set is listed last so it wins if both ever meet in one cycle.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			resume_flag_q <= 1'b0;
		end else begin
			if (addr_cmd) begin
				resume_flag_q <= 1'b0;
			end
			if (sel_ok) begin
				resume_flag_q <= 1'b1;
			end
		end
	end

	// Only a long reset leaves overdrive; a failed overdrive match never
	// touches the flag, so a device already fast stays fast.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			overdrive_flag_q <= 1'b0;
		end else begin
			if (rst_det && long_rst) begin
				overdrive_flag_q <= 1'b0;
			end else if (rst_det && short_rst) begin
				overdrive_flag_q <= overdrive_flag_q;
			end
			if (cmd_take && cmd_byte == swr_pkg::CMD_OD_SKIP) begin
				overdrive_flag_q <= 1'b1;
			end
			if (sel_ok && od_match_q) begin
				overdrive_flag_q <= 1'b1;
			end
		end
	end

	// Hand-over to the function command layer.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			func_go_q     <= 1'b0;
			func_active_q <= 1'b0;
		end else begin
			func_go_q     <= (st_d == swr_pkg::SWR_FUNC) &&
					 (st_q != swr_pkg::SWR_FUNC);
			func_active_q <= (st_d == swr_pkg::SWR_FUNC);
		end
	end

	// The line is never driven high; the enable asks for a pull-down in the
	// coming read slot. Because the identity bit is registered, the request
	// trails an index step by two cycles, far inside any slot gap.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			od_line_o_q  <= 1'b0;
			od_line_oe_q <= 1'b0;
		end else begin
			od_line_o_q <= 1'b0;
			unique case (st_q)
			swr_pkg::SWR_READ_ID,
			swr_pkg::SWR_SRCH_TRU: begin
				od_line_oe_q <= ~id_bit;
			end
			swr_pkg::SWR_SRCH_CMP: begin
				od_line_oe_q <= id_bit;
			end
			swr_pkg::SWR_WAIT_RST,
			swr_pkg::SWR_CMD,
			swr_pkg::SWR_MATCH,
			swr_pkg::SWR_SRCH_DIR,
			swr_pkg::SWR_FUNC: begin
				od_line_oe_q <= 1'b0;
			end
			endcase
		end
	end

endmodule // swr_rom_layer
`default_nettype wire

/* dv/swr_rom_layer_checker.sv */
// Checker for the ROM command layer, bound to every layer instance.
// Assumes one clock domain and the hand-over latencies of the layer.
`timescale 1ns/10ps
`default_nettype none
module swr_rom_layer_checker #(
	parameter int RST_CNT_W     = 17,
	parameter int RST_LONG_CYC  = 86250,
	parameter int RST_SHORT_CYC = 10000
) (
	input wire logic                 sys_clk,
	input wire logic                 rst_n,
	input wire logic                 rst_det,
	input wire logic [RST_CNT_W-1:0] rst_low_cyc,
	input wire logic                 od_line_o_q,
	input wire logic                 overdrive_flag_q,
	input wire logic                 resume_flag_q,
	input wire logic                 func_go_q,
	input wire logic                 func_active_q,
	input wire logic [7:0]           rom_cmd_q
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_line_low_only: assert property (!od_line_o_q)
		else $error("line driven high");
	a_go_known_cmd: assert property (func_go_q |-> rom_cmd_q inside
		{8'h33, 8'h55, 8'hF0, 8'hEC, 8'hCC, 8'hA5, 8'h3C, 8'h69})
		else $error("hand-over on unknown command");
	a_skip_handover: assert property ($changed(rom_cmd_q) &&
		(rom_cmd_q inside {8'hCC, 8'h3C} || rom_cmd_q == 8'hA5 && resume_flag_q)
		|-> func_go_q) else $error("no hand-over");
	a_resume_refused: assert property ($changed(rom_cmd_q) &&
		rom_cmd_q == 8'hA5 && !resume_flag_q |-> !func_go_q [*4])
		else $error("resume taken without flag");
	a_resume_cause: assert property ($rose(resume_flag_q) |->
		rom_cmd_q inside {8'h55, 8'hF0, 8'hEC, 8'h69})
		else $error("resume flag set wrongly");
	a_od_cause: assert property ($rose(overdrive_flag_q) |->
		rom_cmd_q inside {8'h3C, 8'h69}) else $error("overdrive set wrongly");
	a_od_long_clear: assert property (rst_det &&
		rst_low_cyc >= RST_LONG_CYC |-> ##[1:3] !overdrive_flag_q)
		else $error("overdrive kept");
	a_od_short_keep: assert property (rst_det && overdrive_flag_q &&
		rst_low_cyc <= RST_SHORT_CYC |=> overdrive_flag_q [*3])
		else $error("overdrive lost");
	a_det_release: assert property (rst_det |-> ##[1:3] !func_active_q)
		else $error("function phase kept");
	c_go: cover property (func_go_q);
	c_od: cover property ($rose(overdrive_flag_q));
	c_res: cover property ($rose(resume_flag_q));
endmodule // swr_rom_layer_checker
bind swr_rom_layer swr_rom_layer_checker #(.RST_CNT_W(RST_CNT_W),
	.RST_LONG_CYC(RST_LONG_CYC), .RST_SHORT_CYC(RST_SHORT_CYC)) i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .rst_det(rst_det),
	.rst_low_cyc(rst_low_cyc), .od_line_o_q(od_line_o_q),
	.overdrive_flag_q(overdrive_flag_q), .resume_flag_q(resume_flag_q),
	.func_go_q(func_go_q), .func_active_q(func_active_q),
	.rom_cmd_q(rom_cmd_q));
`default_nettype wire

/* dv/swr_mst.sv */
// Bus master model: bus reset, write slots and read slots.
// Assumes a pull-up on the line and task calls from the bench.
`timescale 1ns/10ps
`default_nettype none
module swr_mst (
	input  wire logic   sys_clk,
	input  wire logic   line,
	output logic        rst_det,
	output logic [16:0] rst_low_cyc,
	output logic        wr_bit_stb,
	output logic        wr_bit_val,
	output logic        rd_slot_stb
);
	initial begin
		{rst_det, rst_low_cyc, wr_bit_stb, wr_bit_val, rd_slot_stb} = '0;
	end
	// Idle cycles stand in for slot recovery and keep strobes apart.
	task automatic gap();
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic bus_rst(input int n);
		@(negedge sys_clk);
		rst_det = 1'b1;
		rst_low_cyc = 17'(n);
		@(negedge sys_clk);
		rst_det = 1'b0;
		gap();
	endtask
	task automatic wr(input logic b);
		@(negedge sys_clk);
		wr_bit_stb = 1'b1;
		wr_bit_val = b;
		@(negedge sys_clk);
		wr_bit_stb = 1'b0;
		wr_bit_val = !b;
		gap();
	endtask
	task automatic wr_byte(input logic [7:0] c);
		for (int i = 0; i < 8; i++) begin
			wr(c[i]);
		end
		gap();
	endtask
	task automatic rd(output logic b);
		b = line;
		@(negedge sys_clk);
		rd_slot_stb = 1'b1;
		@(negedge sys_clk);
		rd_slot_stb = 1'b0;
		gap();
	endtask
endmodule // swr_mst
`default_nettype wire

/* dv/tb_swr_rom_layer.sv */
// Self-checking bench for the ROM command layer with a bus master model.
// Assumes the checker binds itself to the layer.
`timescale 1ns/10ps
`default_nettype none
module tb_swr_rom_layer;
	localparam logic [7:0]  FAM = 8'hA7; // Arbitrary value.
	localparam logic [47:0] SER = 48'h00000A5B3C7D; // Arbitrary value.
	logic        sys_clk, rst_n, temp_alarm_en, hum_alarm_en;
	logic        rst_det, wr_bit_stb, wr_bit_val, rd_slot_stb;
	logic [16:0] rst_low_cyc;
	logic [7:0]  alarm_flags, cmd;
	logic        oe, o, od, res, go, act, b;
	logic [63:0] id;
	wire         line;
	int          num_errors, n_checks, n_go, cyc;
	assign line = !(oe && !o);
	swr_rom_layer #(.FAMILY(FAM), .SERIAL(SER), .RST_LONG_CYC(200),
		.RST_SHORT_CYC(20)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .rst_det(rst_det),
		.rst_low_cyc(rst_low_cyc), .wr_bit_stb(wr_bit_stb),
		.wr_bit_val(wr_bit_val), .rd_slot_stb(rd_slot_stb),
		.alarm_flags(alarm_flags), .temp_alarm_en(temp_alarm_en),
		.hum_alarm_en(hum_alarm_en), .od_line_o_q(o), .od_line_oe_q(oe),
		.overdrive_flag_q(od), .resume_flag_q(res), .func_go_q(go),
		.func_active_q(act), .rom_cmd_q(cmd));
	swr_mst i_mst (.sys_clk(sys_clk), .line(line), .rst_det(rst_det),
		.rst_low_cyc(rst_low_cyc), .wr_bit_stb(wr_bit_stb),
		.wr_bit_val(wr_bit_val), .rd_slot_stb(rd_slot_stb));
	always #4 sys_clk = ~sys_clk;
	// The run needs about 12300 cycles; the ceiling leaves ample room.
	always @(posedge sys_clk) begin
		cyc++;
		n_go += (go === 1'b1);
		if (cyc == 40000) begin
			num_errors++;
			wrap_up();
		end
	end
	function automatic logic [7:0] crc(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
		end
		return c;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic sel(input logic [7:0] c, input logic [63:0] v, input int n);
		i_mst.bus_rst(n);
		i_mst.wr_byte(c);
		for (int i = 0; i < 64; i++) begin
			i_mst.wr(v[i]);
		end
	endtask
	task automatic srch(input logic [7:0] c, input int flip, input logic part);
		logic t, f;
		int g;
		g = n_go;
		i_mst.bus_rst(100);
		i_mst.wr_byte(c);
		for (int i = 0; i < 64; i++) begin
			i_mst.rd(t);
			i_mst.rd(f);
			chk({t, f}, (part && i <= flip) ? {id[i], !id[i]} : 2'b11);
			i_mst.wr(id[i] ^ (i == flip));
		end
		chk(n_go - g, part && flip > 63);
		chk(res, part && flip > 63);
	endtask
	task automatic t_skip();
		int g;
		g = n_go;
		i_mst.bus_rst(200);
		i_mst.wr_byte(8'hCC);
		chk(cmd, 8'hCC);
		chk(n_go - g, 1);
		chk(act, 1'b1);
	endtask
	task automatic t_unknown();
		int g;
		g = n_go;
		i_mst.bus_rst(200);
		i_mst.wr_byte(8'h00);
		i_mst.rd(b);
		chk(b, 1'b1);
		i_mst.wr_byte(8'hCC);
		chk(n_go - g, 0);
	endtask
	task automatic t_read_id();
		logic [63:0] r;
		int g;
		g = n_go;
		i_mst.bus_rst(100);
		i_mst.wr_byte(8'h33);
		for (int i = 0; i < 64; i++) begin
			i_mst.rd(r[i]);
		end
		chk(r, id);
		chk(n_go - g, 1);
	endtask
	task automatic t_match();
		int g;
		g = n_go;
		sel(8'h55, id, 100);
		chk(n_go - g, 1);
		chk(res, 1'b1);
		for (int k = 0; k < 2; k++) begin
			i_mst.bus_rst(100);
			i_mst.wr_byte(8'hA5);
		end
		chk(n_go - g, 3);
		sel(8'h55, id ^ 64'h0000010000000000, 100);
		i_mst.rd(b);
		chk(b, 1'b1);
		chk(res, 1'b0);
		i_mst.bus_rst(100);
		i_mst.wr_byte(8'hA5);
		chk(n_go - g, 3);
	endtask
	task automatic t_alarm();
		srch(8'hEC, 64, 1'b0);
		alarm_flags = 8'h03;
		srch(8'hEC, 64, 1'b0);
		temp_alarm_en = 1'b1;
		srch(8'hEC, 64, 1'b1);
		alarm_flags = 8'hEC;
		srch(8'hEC, 64, 1'b0);
		hum_alarm_en = 1'b1;
		srch(8'hEC, 0, 1'b1);
		{alarm_flags, temp_alarm_en, hum_alarm_en} = 10'h040;
		srch(8'hEC, 64, 1'b1);
	endtask
	task automatic t_overdrive();
		int g;
		g = n_go;
		i_mst.bus_rst(200);
		i_mst.wr_byte(8'h3C);
		chk(od, 1'b1);
		chk(n_go - g, 1);
		sel(8'h69, id ^ 64'h1, 20);
		chk(od, 1'b1);
		i_mst.bus_rst(200);
		chk(od, 1'b0);
		sel(8'h69, id, 100);
		chk(od, 1'b1);
		chk(res, 1'b1);
		i_mst.bus_rst(199);
		chk(od, 1'b1);
		i_mst.bus_rst(131071);
		chk(od, 1'b0);
	endtask
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		{alarm_flags, temp_alarm_en, hum_alarm_en} = 10'h000;
		num_errors = 0;
		n_checks = 0;
		id = {crc({SER, FAM}), SER, FAM};
		repeat (20) @(negedge sys_clk);
		rst_n = 1'b1;
		chk({od, res, go, act, oe}, 5'h00);
		t_skip();
		t_unknown();
		t_read_id();
		t_match();
		srch(8'hF0, 64, 1'b1);
		srch(8'hF0, 5, 1'b1);
		t_alarm();
		t_overdrive();
		wrap_up();
	end
endmodule // tb_swr_rom_layer
`default_nettype wire
